// *** rtl/crsf_pkg.sv ***
// Package for the clock/reset status flag block: offsets, bit positions, resets, types.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz clock.
package crsf_pkg;
   // Register byte offsets
   localparam logic [3:0] CRSF_OFS_FLAGS = 4'h0;
   localparam logic [3:0] CRSF_OFS_ENABLE = 4'h4;
   localparam logic [3:0] CRSF_OFS_DIV = 4'h8;
   // Flag bit positions
   localparam int CRSF_B_TICK = 7;
   localparam int CRSF_B_POR = 6;
   localparam int CRSF_B_LVR = 5;
   localparam int CRSF_B_SETCHG = 4;
   localparam int CRSF_B_SETTLED = 3;
   localparam int CRSF_B_ILA = 2;
   localparam int CRSF_B_OSCCHG = 1;
   localparam int CRSF_B_OSCQ = 0;
   // Sticky write-one-to-clear bits, and bits that may interrupt
   localparam logic [7:0] CRSF_W1C_MASK = 8'hF6;
   localparam logic [7:0] CRSF_IRQ_MASK = 8'h92;
   localparam logic [7:0] CRSF_FLAGS_RST = 8'h00;
   localparam logic [7:0] CRSF_ENABLE_RST = 8'h00;
   localparam logic [4:0] CRSF_DIV_RST = 5'h00;
   // Fixed divide-by-4 while unsettled, as count limit (divide minus 1)
   localparam logic [5:0] CRSF_UNSETTLED_LIM = 6'h03;
   // AXI responses
   localparam logic [1:0] CRSF_RESP_OKAY = 2'h0;
   localparam logic [1:0] CRSF_RESP_SLVERR = 2'h2;

   // Hardware events feeding the flag register
   typedef struct packed {
      logic tick;
      logic por;
      logic lvr;
      logic ila;
   } crsf_evt_t;
endpackage

// *** rtl/crsf_illegal_rst.sv ***
// Illegal-address reset generator: flags CPU accesses to unmapped addresses.
// Assumes the decode hit from all on-chip modules arrives with the access strobe.
`timescale 1ns/10ps
`default_nettype none
module crsf_illegal_rst
   import crsf_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic single_chip,
   input wire logic cpu_access,
   input wire logic cpu_addr_hit,
   output logic sys_reset_req
);
   logic req_q, req_d;

   // One-cycle reset request per illegal access, only in single-chip modes
   always_comb begin
      req_d = single_chip && cpu_access && !cpu_addr_hit;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         req_q <= 1'b0;
      end else begin
         req_q <= req_d;
      end
   end

   assign sys_reset_req = req_q;

   property p_ila_req;
      @(posedge clk) disable iff (srst)
      (single_chip && cpu_access && !cpu_addr_hit) |=> sys_reset_req;
   endproperty
   a_ila_req: assert property (p_ila_req) else $error("illegal access gave no reset");
endmodule
`default_nettype wire

// *** rtl/crsf_pll_div.sv ***
// PLL output divider: slow fixed divide until settled, then programmed divide.
// Assumes the VCO is represented by a clock-rate enable pulse in the bus domain.
`timescale 1ns/10ps
`default_nettype none
module crsf_pll_div
   import crsf_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic vco_tick,
   input wire logic settled,
   input wire logic [4:0] pll_post_divider,
   output logic pll_tick
);
   logic [5:0] cnt_q, cnt_d;
   logic [5:0] lim;
   logic out_q, out_d;

   // Limit chosen by settled status; counter restarts when it would overrun
   always_comb begin
      lim = settled ? {1'b0, pll_post_divider} : CRSF_UNSETTLED_LIM;
      cnt_d = cnt_q;
      out_d = 1'b0;
      if (vco_tick) begin
         if (cnt_q >= lim) begin
            cnt_d = 6'h00;
            out_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= 6'h00;
         out_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign pll_tick = out_q;

   // Three quiet cycles after an output pulse
   sequence s_quiet3;
      !pll_tick ##1 !pll_tick ##1 !pll_tick;
   endsequence

   property p_slow_when_unsettled;
      @(posedge clk) disable iff (srst)
      (pll_tick && !settled && $stable(settled)) |-> ##1 s_quiet3;
   endproperty
   a_slow_when_unsettled: assert property (p_slow_when_unsettled) else $error("divide below 4");
endmodule
`default_nettype wire

// *** rtl/crsf_top.sv ***
// Clock/reset status flags with AXI4-Lite slave and one level interrupt.
// Assumes events are one-cycle pulses and status inputs are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module crsf_top
   import crsf_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic periodic_tick,
   input wire logic por_event,
   input wire logic lvr_event,
   input wire logic pll_settled_in,
   input wire logic osc_qualified_in,
   input wire logic full_stop,
   input wire logic single_chip,
   input wire logic cpu_access,
   input wire logic cpu_addr_hit,
   input wire logic vco_clock,
   output logic pll_clock_tick,
   output logic sys_reset,
   output logic irq
);
   crsf_evt_t evt;
   logic ila_req;
   logic pll_tick;
   logic [7:0] flags_q, flags_d;
   logic [2:0] ien_q, ien_d;
   logic [4:0] div_q, div_d;
   logic settled_q, settled_d;
   logic oscq_q, oscq_d;
   logic irq_q, irq_d;
   logic sysrst_q, sysrst_d;
   logic pllo_q;
   logic aw_q, aw_d, w_q, w_d;
   logic [3:0] awa_q, awa_d;
   logic [7:0] wd_q, wd_d;
   logic wst_q, wst_d;
   logic bv_q, bv_d;
   logic [1:0] br_q, br_d;
   logic rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0] rr_q, rr_d;
   logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
   logic wr_fire;
   logic [7:0] clr;
   logic [7:0] live;

   crsf_illegal_rst u_ila (
      .clk(clk),
      .srst(srst),
      .single_chip(single_chip),
      .cpu_access(cpu_access),
      .cpu_addr_hit(cpu_addr_hit),
      .sys_reset_req(ila_req)
   );

   crsf_pll_div u_div (
      .clk(clk),
      .srst(srst),
      .vco_tick(vco_clock),
      .settled(settled_q),
      .pll_post_divider(div_q),
      .pll_tick(pll_tick)
   );

   // Event bundle for the sticky flags
   always_comb begin
      evt.tick = periodic_tick;
      evt.por = por_event;
      evt.lvr = lvr_event;
      evt.ila = ila_req;
   end

   // AXI write side: address and data taken in either order, response after both
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      wst_d = wst_q;
      bv_d = bv_q;
      br_d = br_q;
      wr_fire = 1'b0;
      if (s_axi_awvalid && !aw_q && !bv_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q && !bv_q) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata[7:0];
         wst_d = s_axi_wstrb[0];
      end
      if (aw_q && w_q) begin
         wr_fire = 1'b1;
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = (awa_q == CRSF_OFS_FLAGS || awa_q == CRSF_OFS_ENABLE ||
                 awa_q == CRSF_OFS_DIV) ? CRSF_RESP_OKAY : CRSF_RESP_SLVERR;
      end else if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      // Ready taken from next state, so the pins leave a flop with no extra delay
      awrdy_d = !aw_d && !bv_d;
      wrdy_d = !w_d && !bv_d;
   end

   // Write-one-to-clear strobes; status bits 3 and 0 are outside the mask, so ignored
   always_comb begin
      clr = '0;
      if (wr_fire && wst_q && awa_q == CRSF_OFS_FLAGS) begin
         clr = wd_q & CRSF_W1C_MASK;
      end
   end

   // Live status: full stop forces oscillator-qualified low
   always_comb begin
      settled_d = pll_settled_in;
      oscq_d = osc_qualified_in && !full_stop;
   end

   // Sticky flags: a set in the same cycle as a clear wins
   always_comb begin
      flags_d = flags_q & ~clr;
      if (evt.tick) flags_d[CRSF_B_TICK] = 1'b1;
      if (evt.por) flags_d[CRSF_B_POR] = 1'b1;
      if (evt.lvr) flags_d[CRSF_B_LVR] = 1'b1;
      if (settled_d != settled_q) flags_d[CRSF_B_SETCHG] = 1'b1;
      if (evt.ila) flags_d[CRSF_B_ILA] = 1'b1;
      if (oscq_d != oscq_q) flags_d[CRSF_B_OSCCHG] = 1'b1;
      flags_d[CRSF_B_SETTLED] = 1'b0;
      flags_d[CRSF_B_OSCQ] = 1'b0;
   end

   // Enables and post-divider, byte lane 0 only
   always_comb begin
      ien_d = ien_q;
      div_d = div_q;
      if (wr_fire && wst_q && awa_q == CRSF_OFS_ENABLE) begin
         ien_d = {wd_q[CRSF_B_TICK], wd_q[CRSF_B_SETCHG], wd_q[CRSF_B_OSCCHG]};
      end
      if (wr_fire && wst_q && awa_q == CRSF_OFS_DIV) begin
         div_d = wd_q[4:0];
      end
   end

   // Interrupt level: held while any enabled flag stands
   always_comb begin
      irq_d = (flags_d[CRSF_B_TICK] && ien_d[2]) ||
              (flags_d[CRSF_B_SETCHG] && ien_d[1]) ||
              (flags_d[CRSF_B_OSCCHG] && ien_d[0]);
      sysrst_d = ila_req;
   end

   // Register read view with live status bits merged in
   always_comb begin
      live = flags_q;
      live[CRSF_B_SETTLED] = settled_q;
      live[CRSF_B_OSCQ] = oscq_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = CRSF_RESP_OKAY;
         unique case (s_axi_araddr)
            CRSF_OFS_FLAGS: rd_d = {24'h000000, live};
            CRSF_OFS_ENABLE: rd_d = {24'h000000, ien_q[2], 2'h0, ien_q[1], 2'h0, ien_q[0], 1'b0};
            CRSF_OFS_DIV: rd_d = {27'h0000000, div_q};
            default: begin
               rd_d = 32'h00000000;
               rr_d = CRSF_RESP_SLVERR;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      arrdy_d = !rv_d;
   end

   // Only state registers; power-on flag is not cleared by srst, a soft reset here
   always_ff @(posedge clk) begin
      if (srst) begin
         flags_q <= CRSF_FLAGS_RST | (flags_q & (8'h01 << CRSF_B_POR));
         ien_q <= CRSF_ENABLE_RST[2:0];
         div_q <= CRSF_DIV_RST;
         settled_q <= 1'b0;
         oscq_q <= 1'b0;
         irq_q <= 1'b0;
         sysrst_q <= 1'b0;
         pllo_q <= 1'b0;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 4'h0;
         wd_q <= 8'h00;
         wst_q <= 1'b0;
         bv_q <= 1'b0;
         br_q <= CRSF_RESP_OKAY;
         rv_q <= 1'b0;
         rd_q <= 32'h00000000;
         rr_q <= CRSF_RESP_OKAY;
         awrdy_q <= 1'b1;
         wrdy_q <= 1'b1;
         arrdy_q <= 1'b1;
      end else begin
         flags_q <= flags_d;
         ien_q <= ien_d;
         div_q <= div_d;
         settled_q <= settled_d;
         oscq_q <= oscq_d;
         irq_q <= irq_d;
         sysrst_q <= sysrst_d;
         pllo_q <= pll_tick;
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         wst_q <= wst_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         awrdy_q <= awrdy_d;
         wrdy_q <= wrdy_d;
         arrdy_q <= arrdy_d;
      end
   end

   assign s_axi_awready = awrdy_q;
   assign s_axi_wready = wrdy_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
   assign pll_clock_tick = pllo_q;
   assign sys_reset = sysrst_q;
   assign irq = irq_q;

   property p_tick_set;
      @(posedge clk) disable iff (srst) periodic_tick |=> flags_q[CRSF_B_TICK];
   endproperty
   a_tick_set: assert property (p_tick_set) else $error("tick flag not set");

   property p_por_hold;
      @(posedge clk) disable iff (srst)
      (flags_q[CRSF_B_POR] && !clr[CRSF_B_POR]) |=> flags_q[CRSF_B_POR];
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("por flag lost");

   property p_lvr_set;
      @(posedge clk) disable iff (srst) lvr_event |=> flags_q[CRSF_B_LVR];
   endproperty
   a_lvr_set: assert property (p_lvr_set) else $error("lvr flag not set");

   property p_settle_chg;
      @(posedge clk) disable iff (srst)
      (pll_settled_in != settled_q) |=> flags_q[CRSF_B_SETCHG];
   endproperty
   a_settle_chg: assert property (p_settle_chg) else $error("settle change missed");

   property p_settled_live;
      @(posedge clk) disable iff (srst) ##1 (settled_q == $past(pll_settled_in));
   endproperty
   a_settled_live: assert property (p_settled_live) else $error("settled bit stale");

   property p_ila_flag;
      @(posedge clk) disable iff (srst)
      (single_chip && cpu_access && !cpu_addr_hit) |=> ##1 flags_q[CRSF_B_ILA];
   endproperty
   a_ila_flag: assert property (p_ila_flag) else $error("illegal flag not set");

   property p_osc_chg;
      @(posedge clk) disable iff (srst) (oscq_d != oscq_q) |=> flags_q[CRSF_B_OSCCHG];
   endproperty
   a_osc_chg: assert property (p_osc_chg) else $error("osc change missed");

   property p_stop_clears;
      @(posedge clk) disable iff (srst) full_stop |=> !oscq_q;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("osc bit high in stop");

   property p_irq_level;
      @(posedge clk) disable iff (srst)
      ##1 (irq == ((flags_q[CRSF_B_TICK] && ien_q[2]) ||
                   (flags_q[CRSF_B_SETCHG] && ien_q[1]) ||
                   (flags_q[CRSF_B_OSCCHG] && ien_q[0])));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
endmodule
`default_nettype wire

// *** test/crsf_tb_top.sv ***
// Self-checking bench for the clock/reset status flag block.
// Assumes crsf_pkg and crsf_top are compiled first; one 25 MHz clock, no partner model.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import crsf_pkg::*;
   logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata;
   logic tick, por, lvr, settled, osc, full_stop, single_chip, cpu_access, cpu_hit, vco;
   logic awready, wready, bvalid, arready, rvalid, pll_tick, sys_reset, irq;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   int num_errors = 0;
   int cmp_count = 0;

   crsf_top dut_u (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .periodic_tick(tick), .por_event(por), .lvr_event(lvr), .pll_settled_in(settled),
      .osc_qualified_in(osc), .full_stop(full_stop), .single_chip(single_chip),
      .cpu_access(cpu_access), .cpu_addr_hit(cpu_hit), .vco_clock(vco),
      .pll_clock_tick(pll_tick), .sys_reset(sys_reset), .irq(irq));

   // Free-running 40 ns clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      test_done();
   end

   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
   endtask

   // Write one word; both channels offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int n;
      logic aw_p, w_p, b_ok;
      n = 0;
      aw_p = 1'b1;
      w_p = 1'b1;
      b_ok = 1'b0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_ok && n < 40) begin
         @(posedge clk);
         n++;
         if (aw_p && awready) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            b_ok = 1'b1;
            rs = bresp;
            bready <= 1'b0;
         end
      end
      chk({31'h0, b_ok}, 32'h1);
   endtask

   task automatic rd_reg(input logic [3:0] a);
      int n;
      logic ar_p, r_ok;
      n = 0;
      ar_p = 1'b1;
      r_ok = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_ok && n < 40) begin
         @(posedge clk);
         n++;
         if (ar_p && arready) begin
            ar_p = 1'b0;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            r_ok = 1'b1;
            rd = rdata;
            rs = rresp;
            rready <= 1'b0;
         end
      end
      chk({31'h0, r_ok}, 32'h1);
   endtask

   // Compare selected flag bits; upper bytes must read zero as well
   task automatic fchk(input logic [7:0] m, input logic [7:0] e);
      rd_reg(CRSF_OFS_FLAGS);
      chk(rd & {24'hFFFFFF, m}, {24'h000000, e});
   endtask

   task automatic evt(input int k);
      @(posedge clk);
      case (k)
         7: tick <= 1'b1;
         6: por <= 1'b1;
         5: lvr <= 1'b1;
         default: ;
      endcase
      @(posedge clk);
      tick <= 1'b0;
      por <= 1'b0;
      lvr <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic irqchk(input logic e);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   // Clean state, then the power-on flag must outlive a second reset
   task automatic t_reset();
      evt(6);
      wr(CRSF_OFS_FLAGS, 8'hFF);
      fchk(8'hFF, 8'h00);
      rd_reg(CRSF_OFS_ENABLE);
      chk(rd, 32'h0);
      rd_reg(CRSF_OFS_DIV);
      chk(rd, 32'h0);
      evt(6);
      do_reset();
      fchk(8'h40, 8'h40);
   endtask

   // Sticky event flags: a zero write keeps them, a one write clears them
   task automatic t_sticky();
      logic [7:0] m;
      for (int b = 5; b < 8; b++) begin
         m = 8'h01 << b;
         evt(b);
         fchk(m, m);
         wr(CRSF_OFS_FLAGS, ~m & 8'hF6);
         fchk(m, m);
         wr(CRSF_OFS_FLAGS, m);
         fchk(m, 8'h00);
      end
   endtask

   task automatic t_status();
      @(posedge clk);
      settled <= 1'b1;
      fchk(8'h18, 8'h18);
      wr(CRSF_OFS_FLAGS, 8'hFF);
      fchk(8'h18, 8'h08);
      @(posedge clk);
      settled <= 1'b0;
      fchk(8'h18, 8'h10);
      @(posedge clk);
      osc <= 1'b1;
      fchk(8'h03, 8'h03);
      wr(CRSF_OFS_FLAGS, 8'hFF);
      fchk(8'h03, 8'h01);
      @(posedge clk);
      full_stop <= 1'b1;
      fchk(8'h01, 8'h00);
      @(posedge clk);
      full_stop <= 1'b0;
      osc <= 1'b0;
      wr(CRSF_OFS_FLAGS, 8'hFF);
   endtask

   // Each interrupting flag: masked, unmasked, masked again, unmasked again, then cleared
   task automatic t_irq();
      logic [7:0] m;
      for (int k = 0; k < 3; k++) begin
         m = (k == 0) ? 8'h80 : (k == 1) ? 8'h10 : 8'h02;
         wr(CRSF_OFS_ENABLE, 8'h00);
         if (k == 0) begin
            evt(7);
         end else begin
            @(posedge clk);
            if (k == 1) settled <= ~settled;
            else osc <= ~osc;
         end
         fchk(m, m);
         irqchk(1'b0);
         wr(CRSF_OFS_ENABLE, m);
         irqchk(1'b1);
         wr(CRSF_OFS_ENABLE, 8'h00);
         irqchk(1'b0);
         wr(CRSF_OFS_ENABLE, m);
         irqchk(1'b1);
         wr(CRSF_OFS_FLAGS, m);
         irqchk(1'b0);
      end
   endtask

   task automatic t_ill(input logic sc, input logic hit, input int e);
      int cnt;
      cnt = 0;
      @(posedge clk);
      single_chip <= sc;
      cpu_hit <= hit;
      @(posedge clk);
      cpu_access <= 1'b1;
      @(posedge clk);
      cpu_access <= 1'b0;
      repeat (6) begin
         @(posedge clk);
         if (sys_reset === 1'b1) cnt++;
      end
      chk(32'(cnt), 32'(e));
      fchk(8'h04, (e != 0) ? 8'h04 : 8'h00);
      wr(CRSF_OFS_FLAGS, 8'h00);
      fchk(8'h04, (e != 0) ? 8'h04 : 8'h00);
      wr(CRSF_OFS_FLAGS, 8'h04);
      fchk(8'h04, 8'h00);
   endtask

   // Output pulses over 60 VCO pulses; 60 is a multiple of every divide used
   task automatic t_div(input logic s, input logic [7:0] d, input int e);
      int cnt;
      cnt = 0;
      wr(CRSF_OFS_DIV, d);
      @(posedge clk);
      settled <= s;
      vco <= 1'b1;
      repeat (10) @(posedge clk);
      repeat (60) begin
         @(posedge clk);
         if (pll_tick === 1'b1) cnt++;
      end
      vco <= 1'b0;
      chk(32'(cnt), 32'(e));
   endtask

   task automatic t_bus();
      wr(CRSF_OFS_ENABLE, CRSF_IRQ_MASK);
      rd_reg(CRSF_OFS_ENABLE);
      chk(rd, 32'h92);
      chk({30'h0, rs}, {30'h0, CRSF_RESP_OKAY});
      wr(CRSF_OFS_ENABLE, 8'h00);
      // Byte lane 0 strobe low: the write must leave the enables alone
      @(posedge clk);
      wstrb <= 4'hE;
      wr(CRSF_OFS_ENABLE, 8'h92);
      rd_reg(CRSF_OFS_ENABLE);
      chk(rd, 32'h0);
      wstrb <= 4'hF;
      rd_reg(4'hC);
      chk({30'h0, rs}, {30'h0, CRSF_RESP_SLVERR});
      chk(rd, 32'h0);
      wr(4'hC, 8'hFF);
      chk({30'h0, rs}, {30'h0, CRSF_RESP_SLVERR});
   endtask

   initial begin
      srst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 4'h0;
      araddr = 4'h0;
      wstrb = 4'hF;
      wdata = 32'h0;
      {tick, por, lvr, settled, osc, full_stop} = 6'h00;
      {single_chip, cpu_access, cpu_hit, vco} = 4'h0;
      do_reset();
      t_reset();
      t_sticky();
      t_status();
      t_irq();
      t_ill(1'b1, 1'b0, 1);
      t_ill(1'b1, 1'b1, 0);
      t_ill(1'b0, 1'b0, 0);
      t_div(1'b0, 8'h04, 15);
      t_div(1'b1, 8'h04, 12);
      t_div(1'b1, 8'h00, 60);
      t_div(1'b1, 8'h02, 20);
      t_bus();
      test_done();
   end
endmodule
`default_nettype wire
